// ==== rtl/dmr_regs.v ====
// APB register map of the twelve-channel DMA controller: main block and channels.
//
// Overview of operation
// - Channel address is base plus channel offset plus register offset; main at 000h.
// - Main block holds global control at 00h and packet snapshot at 04h.
// - Writing one to global control bit 1 resets the module; self-clearing, write-only.
// - Global control bit 0 enables the block; clearing it disables all channels.
// - Global enable alone runs no channel; each channel needs its own enable.
// - Packet snapshot is a read-only 32-bit copy of transfer data, reset zero.
// - Each channel has enable, addresses, control, status, int enable, test at 00h-1Ch.
// - Only channel 0 has CRC registers at 20h-2Ch; reserved elsewhere.
// - Only channel 1 has fill registers at 20h-2Ch; reserved elsewhere.
// - A channel runs only while its own enable and the global enable are set.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module dmr_regs #(
    parameter NUM_CHAN = 12,
    parameter AW       = 10
) (
    // Clock and reset
    input  wire                     pclk,
    input  wire                     presetn,
    // APB slave
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [AW-1:0]            paddr,
    input  wire [31:0]              pwdata,
    output reg  [31:0]              prdata,
    output reg                      pready,
    output reg                      pslverr,
    // Transfer data path
    input  wire [31:0]              packet_data,
    input  wire                     packet_load,
    // Channel status from the transfer engine
    input  wire [NUM_CHAN*8-1:0]    chan_status_set,
    input  wire [31:0]              crc_post_status,
    input  wire [31:0]              fill_status,
    // Channel controls to the transfer engine
    output reg  [NUM_CHAN-1:0]      chan_active,
    output wire [NUM_CHAN*32-1:0]   chan_mem_start,
    output wire [NUM_CHAN*32-1:0]   chan_mem_end,
    output wire [NUM_CHAN*32-1:0]   chan_dev_addr,
    output wire [NUM_CHAN*32-1:0]   chan_control,
    output wire [NUM_CHAN*8-1:0]    chan_int_enable,
    output wire                     crc_enable,
    output wire [31:0]              crc_data,
    output wire                     fill_enable,
    output wire [31:0]              fill_data,
    output reg                      soft_reset_pulse
);
`include "dmr_map.vh"

    // ------------------------------------------------------------------------
    // Address decode helpers.
    // ------------------------------------------------------------------------
    function [`DMR_BLK_W-1:0] blk_of;
        input [AW-1:0] a;
        begin
            blk_of = a[`DMR_BLK_LSB +: `DMR_BLK_W];
        end
    endfunction

    function [5:0] off_of;
        input [AW-1:0] a;
        begin
            off_of = {a[5:2], 2'b00};
        end
    endfunction

    // ------------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------------
    reg                     activate_reg;
    reg  [31:0]             packet_reg;
    reg  [31:0]             rd_mux;
    wire                    wr_fire;
    wire                    in_range;
    wire [`DMR_BLK_W-1:0]   blk;
    wire [5:0]              off;
    wire [NUM_CHAN*32-1:0]  chan_rdata;
    wire [NUM_CHAN-1:0]     chan_en;
    wire [NUM_CHAN-1:0]     side_en;
    wire [NUM_CHAN*32-1:0]  side_data;

    assign blk      = blk_of(paddr);
    assign off      = off_of(paddr);
    assign in_range = (paddr < (`DMR_CHAN_LAST_BASE + `DMR_CHAN_STRIDE));
    assign wr_fire  = psel && penable && pready && pwrite && in_range;

    // ------------------------------------------------------------------------
    // APB handshake: zero wait states, data staged in the setup cycle.
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite)
                prdata <= rd_mux;
            else if (pready)
                prdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Main block registers.
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            activate_reg     <= `DMR_GC_RESET;
            soft_reset_pulse <= 1'b0;
            packet_reg       <= `DMR_PACKET_RESET;
        end else if (soft_reset_pulse) begin
            activate_reg     <= `DMR_GC_RESET;
            soft_reset_pulse <= 1'b0;
            packet_reg       <= `DMR_PACKET_RESET;
        end else begin
            if (wr_fire && blk == 0 && off == `DMR_OFF_GLOBAL_CTRL) begin
                activate_reg     <= pwdata[`DMR_GC_ACTIVATE];
                soft_reset_pulse <= pwdata[`DMR_GC_SOFT_RESET];
            end
            if (packet_load)
                packet_reg <= packet_data;
        end
    end

    // ------------------------------------------------------------------------
    // Channel run gating.
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            chan_active <= {NUM_CHAN{1'b0}};
        else if (soft_reset_pulse)
            chan_active <= {NUM_CHAN{1'b0}};
        else
            chan_active <= chan_en & {NUM_CHAN{activate_reg}};
    end

    // ------------------------------------------------------------------------
    // Channel register blocks.
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g = g + 1) begin : g_chan
            localparam SIDE = (g == `DMR_CRC_CHAN)  ? `DMR_SIDE_CRC :
                              (g == `DMR_FILL_CHAN) ? `DMR_SIDE_FILL :
                                                      `DMR_SIDE_NONE;
            wire [31:0] side_stat_in;
            assign side_stat_in = (g == `DMR_CRC_CHAN)  ? crc_post_status :
                                  (g == `DMR_FILL_CHAN) ? fill_status : 32'h0;
            dmr_chan #(
                .SIDE          (SIDE)
            ) i_dmr_chan (
                .pclk          (pclk),
                .presetn       (presetn),
                .soft_clr      (soft_reset_pulse),
                .wr_en         (wr_fire && blk == g + 1),
                .wr_off        (off),
                .wdata         (pwdata),
                .rd_off        (off),
                .rdata         (chan_rdata[g*32 +: 32]),
                .status_set    (chan_status_set[g*8 +: 8]),
                .side_status   (side_stat_in),
                .enable_reg    (chan_en[g]),
                .mem_start_reg (chan_mem_start[g*32 +: 32]),
                .mem_end_reg   (chan_mem_end[g*32 +: 32]),
                .dev_addr_reg  (chan_dev_addr[g*32 +: 32]),
                .control_reg   (chan_control[g*32 +: 32]),
                .int_en_reg    (chan_int_enable[g*8 +: 8]),
                .side_en_reg   (side_en[g]),
                .side_data_reg (side_data[g*32 +: 32])
            );
        end
    endgenerate

    assign crc_enable  = side_en[`DMR_CRC_CHAN];
    assign crc_data    = side_data[`DMR_CRC_CHAN*32 +: 32];
    assign fill_enable = side_en[`DMR_FILL_CHAN];
    assign fill_data   = side_data[`DMR_FILL_CHAN*32 +: 32];

    // ------------------------------------------------------------------------
    // Read multiplexer across blocks.
    // ------------------------------------------------------------------------
    integer i;
    always @* begin
        rd_mux = 32'h0;
        if (!in_range) begin
            rd_mux = 32'h0;
        end else if (blk == 0) begin
            case (off)
                `DMR_OFF_GLOBAL_CTRL: rd_mux = {31'h0, activate_reg};
                `DMR_OFF_PACKET:      rd_mux = packet_reg;
                default:              rd_mux = 32'h0;
            endcase
        end else begin
            for (i = 0; i < NUM_CHAN; i = i + 1) begin
                if (blk == i + 1)
                    rd_mux = chan_rdata[i*32 +: 32];
            end
        end
    end

endmodule // dmr_regs

// ==== rtl/dmr_map.vh ====
// Address map, field positions, reset values and sizes of the DMA register block.
`ifndef DMR_MAP_VH
`define DMR_MAP_VH

// ----------------------------------------------------------------------------
// Block layout
// ----------------------------------------------------------------------------
`define DMR_MAIN_BASE      10'h000
`define DMR_CHAN0_BASE     10'h040
`define DMR_CHAN_STRIDE    10'h040
`define DMR_CHAN_LAST_BASE 10'h300
`define DMR_NUM_CHAN       12
`define DMR_BLK_LSB        6
`define DMR_BLK_W          4

// ----------------------------------------------------------------------------
// Main block offsets and fields
// ----------------------------------------------------------------------------
`define DMR_OFF_GLOBAL_CTRL 6'h00
`define DMR_OFF_PACKET      6'h04
`define DMR_GC_ACTIVATE     0
`define DMR_GC_SOFT_RESET   1
`define DMR_GC_RESET        1'h0
`define DMR_PACKET_RESET    32'h0000_0000

// ----------------------------------------------------------------------------
// Channel block offsets
// ----------------------------------------------------------------------------
`define DMR_OFF_CH_ENABLE    6'h00
`define DMR_OFF_CH_MEM_START 6'h04
`define DMR_OFF_CH_MEM_END   6'h08
`define DMR_OFF_CH_DEV_ADDR  6'h0c
`define DMR_OFF_CH_CONTROL   6'h10
`define DMR_OFF_CH_INT_STAT  6'h14
`define DMR_OFF_CH_INT_EN    6'h18
`define DMR_OFF_CH_TEST      6'h1c
`define DMR_OFF_CH_SIDE_EN   6'h20
`define DMR_OFF_CH_SIDE_DATA 6'h24
`define DMR_OFF_CH_SIDE_STAT 6'h28
`define DMR_OFF_CH_SIDE_TEST 6'h2c

// ----------------------------------------------------------------------------
// Channel fields and reset values
// ----------------------------------------------------------------------------
`define DMR_CH_ENABLE_BIT  0
`define DMR_INT_W          8
`define DMR_CH_RESET       32'h0000_0000
`define DMR_INT_RESET      8'h00

// ----------------------------------------------------------------------------
// Optional hardware kinds of a channel
// ----------------------------------------------------------------------------
`define DMR_SIDE_NONE      0
`define DMR_SIDE_CRC       1
`define DMR_SIDE_FILL      2
`define DMR_CRC_CHAN       0
`define DMR_FILL_CHAN      1

`endif

// ==== rtl/dmr_chan.v ====
// One channel register block of the DMA register map.
`timescale 1ns/1ps
module dmr_chan #(
    parameter SIDE = 0
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    input  wire        soft_clr,
    // Register access
    input  wire        wr_en,
    input  wire [5:0]  wr_off,
    input  wire [31:0] wdata,
    input  wire [5:0]  rd_off,
    output reg  [31:0] rdata,
    // Hardware status
    input  wire [7:0]  status_set,
    input  wire [31:0] side_status,
    // Configuration out
    output reg         enable_reg,
    output reg  [31:0] mem_start_reg,
    output reg  [31:0] mem_end_reg,
    output reg  [31:0] dev_addr_reg,
    output reg  [31:0] control_reg,
    output reg  [7:0]  int_en_reg,
    output reg         side_en_reg,
    output reg  [31:0] side_data_reg
);
`include "dmr_map.vh"

    reg  [7:0]  int_stat_reg;
    reg  [31:0] test_reg;
    reg  [31:0] side_test_reg;
    wire        has_side = (SIDE != `DMR_SIDE_NONE);

    // ------------------------------------------------------------------------
    // Register writes.
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg    <= 1'b0;
            mem_start_reg <= `DMR_CH_RESET;
            mem_end_reg   <= `DMR_CH_RESET;
            dev_addr_reg  <= `DMR_CH_RESET;
            control_reg   <= `DMR_CH_RESET;
            int_stat_reg  <= `DMR_INT_RESET;
            int_en_reg    <= `DMR_INT_RESET;
            test_reg      <= `DMR_CH_RESET;
            side_en_reg   <= 1'b0;
            side_data_reg <= `DMR_CH_RESET;
            side_test_reg <= `DMR_CH_RESET;
        end else if (soft_clr) begin
            enable_reg    <= 1'b0;
            mem_start_reg <= `DMR_CH_RESET;
            mem_end_reg   <= `DMR_CH_RESET;
            dev_addr_reg  <= `DMR_CH_RESET;
            control_reg   <= `DMR_CH_RESET;
            int_stat_reg  <= `DMR_INT_RESET;
            int_en_reg    <= `DMR_INT_RESET;
            test_reg      <= `DMR_CH_RESET;
            side_en_reg   <= 1'b0;
            side_data_reg <= `DMR_CH_RESET;
            side_test_reg <= `DMR_CH_RESET;
        end else begin
            // Hardware set wins over a software clear in the same cycle.
            if (wr_en && wr_off == `DMR_OFF_CH_INT_STAT)
                int_stat_reg <= (int_stat_reg & ~wdata[7:0]) | status_set;
            else
                int_stat_reg <= int_stat_reg | status_set;
            if (wr_en) begin
                case (wr_off)
                    `DMR_OFF_CH_ENABLE:    enable_reg    <= wdata[`DMR_CH_ENABLE_BIT];
                    `DMR_OFF_CH_MEM_START: mem_start_reg <= wdata;
                    `DMR_OFF_CH_MEM_END:   mem_end_reg   <= wdata;
                    `DMR_OFF_CH_DEV_ADDR:  dev_addr_reg  <= wdata;
                    `DMR_OFF_CH_CONTROL:   control_reg   <= wdata;
                    `DMR_OFF_CH_INT_EN:    int_en_reg    <= wdata[7:0];
                    `DMR_OFF_CH_TEST:      test_reg      <= wdata;
                    `DMR_OFF_CH_SIDE_EN: begin
                        if (has_side)
                            side_en_reg <= wdata[0];
                    end
                    `DMR_OFF_CH_SIDE_DATA: begin
                        if (has_side)
                            side_data_reg <= wdata;
                    end
                    `DMR_OFF_CH_SIDE_TEST: begin
                        if (has_side)
                            side_test_reg <= wdata;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read multiplexer.
    // ------------------------------------------------------------------------
    always @* begin
        case (rd_off)
            `DMR_OFF_CH_ENABLE:    rdata = {31'h0, enable_reg};
            `DMR_OFF_CH_MEM_START: rdata = mem_start_reg;
            `DMR_OFF_CH_MEM_END:   rdata = mem_end_reg;
            `DMR_OFF_CH_DEV_ADDR:  rdata = dev_addr_reg;
            `DMR_OFF_CH_CONTROL:   rdata = control_reg;
            `DMR_OFF_CH_INT_STAT:  rdata = {24'h0, int_stat_reg};
            `DMR_OFF_CH_INT_EN:    rdata = {24'h0, int_en_reg};
            `DMR_OFF_CH_TEST:      rdata = test_reg;
            `DMR_OFF_CH_SIDE_EN:   rdata = has_side ? {31'h0, side_en_reg} : 32'h0;
            `DMR_OFF_CH_SIDE_DATA: rdata = has_side ? side_data_reg : 32'h0;
            `DMR_OFF_CH_SIDE_STAT: rdata = has_side ? side_status : 32'h0;
            `DMR_OFF_CH_SIDE_TEST: rdata = has_side ? side_test_reg : 32'h0;
            default:               rdata = 32'h0;
        endcase
    end

endmodule // dmr_chan

// ==== tb/dmr_regs_checker.sv ====
// Concurrent checks on the ports of the DMA register map.
`timescale 1ns/1ps
module dmr_regs_checker #(
    parameter NUM_CHAN = 12,
    parameter AW       = 10
) (
    input logic                   pclk,
    input logic                   presetn,
    input logic                   psel,
    input logic                   penable,
    input logic                   pwrite,
    input logic [AW-1:0]          paddr,
    input logic [31:0]            pwdata,
    input logic [31:0]            prdata,
    input logic                   pready,
    input logic                   pslverr,
    input logic [NUM_CHAN-1:0]    chan_active,
    input logic [NUM_CHAN*32-1:0] chan_mem_start,
    input logic [NUM_CHAN*32-1:0] chan_control,
    input logic                   crc_enable,
    input logic                   fill_enable,
    input logic                   soft_reset_pulse
);
    // ------------------------------------------------------------------
    // Shared terms
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence soft_wr;
        psel && penable && pready && pwrite && paddr[9:2] == 8'h00 && pwdata[1];
    endsequence
    sequence soft_clear;
        soft_reset_pulse ##1 (chan_mem_start == '0 && !crc_enable) ##1 (chan_active == '0);
    endsequence
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    pready_timing_a: assert property (psel && !penable |=> pready && penable)
        else $error("pready not high in the first access cycle");
    pready_cause_a: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside an access cycle");
    idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside an access");
    no_error_a: assert property (pslverr == 1'b0)
        else $error("slave error raised");
    reserved_read_a: assert property (psel && penable && pready && !pwrite &&
        (paddr >= 10'h340 || (paddr >= 10'h0c0 && paddr[5:0] >= 6'h20) ||
         (paddr < 10'h040 && paddr[5:0] >= 6'h08)) |-> prdata == 32'h0)
        else $error("reserved location read not zero");
    soft_pulse_a: assert property (soft_wr |=> soft_reset_pulse ##1 !soft_reset_pulse)
        else $error("soft reset pulse missing or too long");
    soft_clear_a: assert property (soft_reset_pulse |-> soft_clear)
        else $error("soft reset did not clear the registers");
    pulse_cause_a: assert property ($rose(soft_reset_pulse) |->
        $past(psel && penable && pwrite && pwdata[1] && paddr[9:2] == 8'h00))
        else $error("soft reset pulse without a write");
    global_off_a: assert property (psel && penable && pready && pwrite &&
        paddr[9:2] == 8'h00 && !pwdata[0] |=> ##1 chan_active == '0)
        else $error("channels still active after global disable");
    active_cause_a: assert property ((chan_active & ~$past(chan_active)) != '0 |->
        $past(psel && penable && pwrite, 2))
        else $error("channel became active without a write");
    cfg_stable_a: assert property (!$past(psel && penable && pwrite) &&
        !$past(soft_reset_pulse) |-> $stable(chan_mem_start) && $stable(chan_control))
        else $error("channel configuration changed without a write");
    side_cause_a: assert property ($rose(crc_enable) || $rose(fill_enable) |->
        $past(psel && penable && pwrite && paddr[5:0] == 6'h20))
        else $error("side enable set without a write");
endmodule // dmr_regs_checker

// ==== tb/tb_dmr_regs.sv ====
// Self-checking testbench of the DMA register map.
`timescale 1ns/1ps
module tb_dmr_regs;
    // ------------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------------
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [9:0]   paddr;
    logic [31:0]  pwdata, prdata, packet_data, crc_post_status, fill_status, crc_data;
    logic [31:0]  fill_data, d, sd [2];
    logic         packet_load, crc_enable, fill_enable, soft_reset_pulse;
    logic [95:0]  chan_status_set, chan_int_enable;
    logic [11:0]  chan_active;
    logic [383:0] chan_mem_start, chan_mem_end, chan_dev_addr, chan_control;
    logic [31:0]  q[$];
    int           errors, n_tests;
    dmr_regs #(.NUM_CHAN(12), .AW(10)) i_dmr_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .packet_data(packet_data), .packet_load(packet_load),
        .chan_status_set(chan_status_set), .crc_post_status(crc_post_status),
        .fill_status(fill_status), .chan_active(chan_active), .chan_mem_start(chan_mem_start),
        .chan_mem_end(chan_mem_end), .chan_dev_addr(chan_dev_addr), .chan_control(chan_control),
        .chan_int_enable(chan_int_enable), .crc_enable(crc_enable), .crc_data(crc_data),
        .fill_enable(fill_enable), .fill_data(fill_data), .soft_reset_pulse(soft_reset_pulse));
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize();
        cmp(q.size(), 0);
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task xfer(input logic w, input logic [9:0] a, input logic [31:0] v);
        int k;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= v;
        @(posedge pclk); penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin cmp(32'h0, 32'h1); summarize(); end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [9:0] a, input logic [31:0] v); xfer(1'b1, a, v); endtask
    task rd(input logic [9:0] a, input logic [31:0] e); q.push_back(e); xfer(1'b0, a, 0); endtask
    function logic [9:0] ch(int g, int o); return 10'((g + 1) * 64 + o * 4); endfunction
    function logic [31:0] pick(int g, int o);
        case (o)
            1: return chan_mem_start[g*32+:32];
            2: return chan_mem_end[g*32+:32];
            3: return chan_dev_addr[g*32+:32];
            default: return chan_control[g*32+:32];
        endcase
    endfunction
    // ------------------------------------------------------------------
    // Read data checker
    // ------------------------------------------------------------------
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (q.size() > 0) cmp(prdata, q.pop_front());
            else cmp(32'h0, 32'h1);
        end
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        psel <= 0; penable <= 0; pwrite <= 0; paddr <= 0; pwdata <= 0; presetn <= 0;
        packet_data <= 0; packet_load <= 0; chan_status_set <= 0;
        void'($urandom(71));
        crc_post_status <= $urandom; fill_status <= $urandom;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(10'h000, 0);
        rd(10'h004, 0);
        for (int g = 0; g < 12; g++) for (int o = 0; o < 7; o++) rd(ch(g, o), 0);
        $display("Test reset values done");
        for (int g = 0; g < 12; g++) begin
            for (int o = 1; o < 5; o++) begin
                d = $urandom; wr(ch(g, o), d); rd(ch(g, o), d);
                cmp(pick(g, o), d);
            end
            d = $urandom; wr(ch(g, 6), d); rd(ch(g, 6), {24'h0, d[7:0]});
            cmp({24'h0, chan_int_enable[g*8+:8]}, {24'h0, d[7:0]});
            wr(ch(g, 0), d & 32'hffff_fffe); rd(ch(g, 0), 0);
        end
        d = $urandom;
        chan_status_set[47:40] <= d[7:0];
        @(posedge pclk); chan_status_set <= '0;
        rd(ch(5, 5), {24'h0, d[7:0]});
        wr(ch(5, 5), 32'h0f); rd(ch(5, 5), {24'h0, d[7:4], 4'h0});
        $display("Test channel map done");
        wr(10'h000, 32'hfd); @(posedge pclk); cmp(chan_active, 0);
        rd(10'h000, 1);
        wr(ch(3, 0), 1); @(posedge pclk); cmp(chan_active, 12'h008);
        wr(10'h000, 0); @(posedge pclk); cmp(chan_active, 0);
        wr(10'h000, 1); @(posedge pclk); cmp(chan_active, 12'h008);
        $display("Test enables done");
        d = $urandom;
        packet_data <= d; packet_load <= 1'b1;
        @(posedge pclk); packet_load <= 1'b0; packet_data <= ~d;
        rd(10'h004, d);
        wr(10'h004, ~d); rd(10'h004, d);
        $display("Test snapshot done");
        for (int s = 0; s < 2; s++) begin
            d = $urandom;
            wr(ch(s, 8), 32'hffff_ffff); rd(ch(s, 8), 1);
            wr(ch(s, 9), d); rd(ch(s, 9), d);
            sd[s] = d;
            rd(ch(s, 10), s == 0 ? crc_post_status : fill_status);
        end
        cmp({crc_enable, fill_enable}, 2'b11);
        cmp(crc_data, sd[0]);
        cmp(fill_data, sd[1]);
        for (int g = 2; g < 12; g++) for (int o = 8; o < 12; o++) begin
            wr(ch(g, o), $urandom); rd(ch(g, o), 0);
        end
        wr(10'h340, $urandom); rd(10'h340, 0);
        wr(10'h3fc, $urandom); rd(10'h3fc, 0);
        rd(10'h008, 0);
        $display("Test side registers done");
        wr(10'h000, 32'h3); repeat (3) @(posedge pclk);
        cmp(chan_active, 0);
        rd(10'h000, 0);
        rd(ch(3, 0), 0);
        rd(ch(0, 1), 0);
        rd(10'h004, 0);
        $display("Test soft reset done");
        summarize();
    end
endmodule // tb_dmr_regs
bind dmr_regs dmr_regs_checker #(.NUM_CHAN(NUM_CHAN), .AW(AW)) i_dmr_regs_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_active(chan_active), .chan_mem_start(chan_mem_start), .chan_control(chan_control),
    .crc_enable(crc_enable), .fill_enable(fill_enable), .soft_reset_pulse(soft_reset_pulse));
